// [verilog/cxms_pkg.sv]
package cxms_pkg;

  localparam int WORD_W = 32;
  localparam int SHAMT_W = 5;
  localparam int COND_W = 4;
  localparam int COND_INV_POS = 3;

  // Flag positions inside the saved processor_status_word
  localparam int STATUS_ZERO_POS = 0;
  localparam int STATUS_SIGN_POS = 1;
  localparam int STATUS_OVERFLOW_POS = 2;
  localparam int STATUS_CARRY_POS = 3;

  localparam logic [31:0] CLIP_POS_MAX = 32'h7FFF_FFFF;
  localparam logic [31:0] CLIP_NEG_MAX = 32'h8000_0000;

  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic FLAG_RST = 1'h0;

  localparam logic [31:0] HALF_ADDR_MASK = 32'hFFFF_FFFE;
  localparam logic [31:0] WORD_ADDR_MASK = 32'hFFFF_FFFC;
  localparam logic [31:0] BYTE_DATA_MASK = 32'h0000_00FF;
  localparam logic [31:0] HALF_DATA_MASK = 32'h0000_FFFF;

  localparam logic [3:0] LANES_NONE = 4'h0;
  localparam logic [3:0] LANES_BYTE = 4'h1;
  localparam logic [3:0] LANES_HALF = 4'h3;
  localparam logic [3:0] LANES_WORD = 4'hF;

  localparam logic [1:0] DEST_NONE = 2'h0;
  localparam logic [1:0] DEST_REG2 = 2'h1;
  localparam logic [1:0] DEST_REG3 = 2'h2;

  typedef enum logic [4:0] {
    OP_IDLE,
    OP_CLAMP_MUL_IMM,
    OP_CLAMP_MUL_HIGH,
    OP_UNSIGNED_MUL,
    OP_NOT,
    OP_OR,
    OP_OR_IMM,
    OP_PORT_BYTE,
    OP_PORT_HALF,
    OP_PORT_WORD,
    OP_TRAP_RETURN,
    OP_ASR_REG,
    OP_ASR_IMM,
    OP_LSL_REG,
    OP_LSL_IMM,
    OP_CLAMP_ADD,
    OP_CLAMP_SUB,
    OP_FLAG_TO_REG,
    OP_CONCAT_LSL
  } cxms_op_type;

endpackage : cxms_pkg

// [verilog/cxms_clip.sv]
module cxms_clip #(
  parameter int IN_W = 64
) (
  input wire logic signed [IN_W-1:0] wide,
  output logic [31:0] clipped,
  output logic overflowed
);
  import cxms_pkg::*;

  logic fits;

  // Fits only if every bit above bit 31 copies bit 31
  always_comb
  begin
    fits = (wide[IN_W-1:31] == {(IN_W-31){1'b0}}) || (wide[IN_W-1:31] == {(IN_W-31){1'b1}});
    overflowed = !fits;
    if (fits)
    begin
      clipped = wide[31:0];
    end
    else if (wide[IN_W-1])
    begin
      clipped = CLIP_NEG_MAX;
    end
    else
    begin
      clipped = CLIP_POS_MAX;
    end
  end

endmodule : cxms_clip

// [verilog/cxms_exec.sv]
module cxms_exec (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic ISSUE,
  input wire cxms_pkg::cxms_op_type OPCODE,
  input wire logic [31:0] SRC_REG1,
  input wire logic [31:0] SRC_REG2,
  input wire logic [31:0] SRC_REG3,
  input wire logic [15:0] IMMEDIATE_16BIT,
  input wire logic [4:0] IMMEDIATE_5BIT,
  input wire logic [15:0] DISPLACEMENT_16BIT,
  input wire logic [31:0] SAVED_PC,
  input wire logic [31:0] SAVED_STATUS_WORD,
  input wire logic SATURATION_CLEAR,
  output logic [31:0] RESULT_DATA,
  output logic RESULT_WRITE,
  output logic [1:0] RESULT_DEST,
  output logic [31:0] PRODUCT_HIGH_REGISTER,
  output logic PRODUCT_HIGH_WRITE,
  output logic [31:0] PORT_ADDRESS,
  output logic [31:0] PORT_DATA,
  output logic [3:0] PORT_LANES,
  output logic PORT_WRITE,
  output logic [31:0] PC_VALUE,
  output logic PC_LOAD,
  output logic CARRY_FLAG,
  output logic OVERFLOW_FLAG,
  output logic SIGN_FLAG,
  output logic ZERO_FLAG,
  output logic SATURATION_FLAG
);
  import cxms_pkg::*;

  logic [31:0] imm_sext;
  logic [31:0] imm_zext;
  logic [31:0] port_base;
  logic [4:0] shamt;
  logic signed [63:0] prod_imm;
  logic signed [63:0] prod_reg;
  logic [63:0] prod_u;
  logic [32:0] sum_u;
  logic signed [63:0] sum_wide;
  logic signed [63:0] diff_wide;
  logic [32:0] lsl_w;
  logic [32:0] asr_w;
  logic [63:0] concat_w;
  logic [31:0] clip_mul;
  logic [31:0] clip_add;
  logic [31:0] clip_sub;
  logic ovf_mul;
  logic ovf_add;
  logic ovf_sub;
  logic cond_hit;

  logic [31:0] nxt_result;
  logic nxt_result_we;
  logic [1:0] nxt_dest;
  logic nxt_carry;
  logic nxt_overflow;
  logic nxt_sign;
  logic nxt_zero;
  logic clip_event;

  logic [31:0] result_ff;
  logic result_we_ff;
  logic [1:0] dest_ff;
  logic [31:0] high_ff;
  logic high_we_ff;
  logic [31:0] port_addr_ff;
  logic [31:0] port_data_ff;
  logic [3:0] port_lanes_ff;
  logic port_we_ff;
  logic [31:0] pc_ff;
  logic pc_load_ff;
  logic carry_ff;
  logic overflow_ff;
  logic sign_ff;
  logic zero_ff;
  logic clip_flag_ff;

  // Condition codes; the top bit of the code inverts the base test
  function automatic logic cond_eval(input logic [3:0] code, input logic c, input logic v,
                                     input logic s, input logic z);
    logic base;
    base = 1'b0;
    unique case (code[2:0])
      3'h0: base = v;
      3'h1: base = c;
      3'h2: base = z;
      3'h3: base = c | z;
      3'h4: base = s;
      3'h5: base = 1'b1;
      3'h6: base = s ^ v;
      3'h7: base = (s ^ v) | z;
    endcase
    return base ^ code[COND_INV_POS];
  endfunction : cond_eval

  always_comb
  begin
    imm_sext = {{16{IMMEDIATE_16BIT[15]}}, IMMEDIATE_16BIT};
    imm_zext = {16'h0000, IMMEDIATE_16BIT};
    port_base = SRC_REG1 + {{16{DISPLACEMENT_16BIT[15]}}, DISPLACEMENT_16BIT};
    // Immediate forms count by the zero-extended 5-bit field
    shamt = ((OPCODE == OP_ASR_IMM) || (OPCODE == OP_LSL_IMM)) ? IMMEDIATE_5BIT
            : SRC_REG1[SHAMT_W-1:0];
    prod_imm = $signed({{32{SRC_REG1[31]}}, SRC_REG1}) * $signed({{32{imm_sext[31]}}, imm_sext});
    prod_reg = $signed({{32{SRC_REG1[31]}}, SRC_REG1}) * $signed({{32{SRC_REG2[31]}}, SRC_REG2});
    prod_u = {32'h0000_0000, SRC_REG1} * {32'h0000_0000, SRC_REG2};
    sum_u = {1'b0, SRC_REG1} + {1'b0, SRC_REG2};
    sum_wide = $signed({{32{SRC_REG1[31]}}, SRC_REG1}) + $signed({{32{SRC_REG2[31]}}, SRC_REG2});
    diff_wide = $signed({{32{SRC_REG2[31]}}, SRC_REG2}) - $signed({{32{SRC_REG1[31]}}, SRC_REG1});
    // Extra bit catches the last bit shifted out as carry
    lsl_w = {1'b0, SRC_REG2} << shamt;
    asr_w = 33'($signed({SRC_REG2, 1'b0}) >>> shamt);
    concat_w = {SRC_REG3, SRC_REG2} << shamt;
    cond_hit = cond_eval(IMMEDIATE_5BIT[COND_W-1:0], carry_ff, overflow_ff, sign_ff, zero_ff);
  end

  cxms_clip #(.IN_W(64)) u_clip_mul (
    .wide(prod_imm),
    .clipped(clip_mul),
    .overflowed(ovf_mul)
  );

  cxms_clip #(.IN_W(64)) u_clip_add (
    .wide(sum_wide),
    .clipped(clip_add),
    .overflowed(ovf_add)
  );

  cxms_clip #(.IN_W(64)) u_clip_sub (
    .wide(diff_wide),
    .clipped(clip_sub),
    .overflowed(ovf_sub)
  );

  always_comb
  begin
    nxt_result = WORD_RST;
    nxt_result_we = 1'b0;
    nxt_dest = DEST_NONE;
    nxt_carry = carry_ff;
    nxt_overflow = overflow_ff;
    nxt_sign = sign_ff;
    nxt_zero = zero_ff;
    clip_event = 1'b0;
    if (ISSUE)
    begin
      unique case (OPCODE)
        OP_CLAMP_MUL_IMM:
        begin
          nxt_result = clip_mul;
          nxt_result_we = 1'b1;
          nxt_dest = DEST_REG2;
          clip_event = ovf_mul;
        end
        OP_CLAMP_MUL_HIGH:
        begin
          // Upper word of a 32x32 signed product always fits
          nxt_result = prod_reg[63:32];
          nxt_result_we = 1'b1;
          nxt_dest = DEST_REG3;
        end
        OP_UNSIGNED_MUL:
        begin
          nxt_result = prod_u[31:0];
          nxt_result_we = 1'b1;
          nxt_dest = DEST_REG2;
          nxt_overflow = |prod_u[63:32];
          nxt_sign = prod_u[63];
          nxt_zero = (prod_u == 64'h0000_0000_0000_0000);
        end
        OP_NOT, OP_OR, OP_OR_IMM:
        begin
          unique case (OPCODE)
            OP_NOT: nxt_result = ~SRC_REG1;
            OP_OR: nxt_result = SRC_REG1 | SRC_REG2;
            default: nxt_result = SRC_REG1 | imm_zext;
          endcase
          nxt_result_we = 1'b1;
          nxt_dest = DEST_REG2;
          nxt_overflow = 1'b0;
          nxt_sign = nxt_result[31];
          nxt_zero = (nxt_result == WORD_RST);
        end
        OP_ASR_REG, OP_ASR_IMM, OP_LSL_REG, OP_LSL_IMM:
        begin
          if ((OPCODE == OP_ASR_REG) || (OPCODE == OP_ASR_IMM))
          begin
            nxt_result = asr_w[32:1];
            nxt_carry = asr_w[0];
          end
          else
          begin
            nxt_result = lsl_w[31:0];
            nxt_carry = lsl_w[32];
          end
          nxt_result_we = 1'b1;
          nxt_dest = DEST_REG2;
          nxt_overflow = 1'b0;
          nxt_sign = nxt_result[31];
          nxt_zero = (nxt_result == WORD_RST);
        end
        OP_CLAMP_ADD, OP_CLAMP_SUB:
        begin
          if (OPCODE == OP_CLAMP_ADD)
          begin
            nxt_result = clip_add;
            nxt_carry = sum_u[32];
            nxt_overflow = ovf_add;
          end
          else
          begin
            nxt_result = clip_sub;
            nxt_carry = (SRC_REG2 < SRC_REG1);
            nxt_overflow = ovf_sub;
          end
          clip_event = nxt_overflow;
          nxt_result_we = 1'b1;
          nxt_dest = DEST_REG3;
          nxt_sign = nxt_result[31];
          nxt_zero = (nxt_result == WORD_RST);
        end
        OP_FLAG_TO_REG:
        begin
          nxt_result = {31'h0000_0000, cond_hit};
          nxt_result_we = 1'b1;
          nxt_dest = DEST_REG2;
        end
        OP_CONCAT_LSL:
        begin
          nxt_result = concat_w[63:32];
          nxt_result_we = 1'b1;
          nxt_dest = DEST_REG3;
        end
        OP_TRAP_RETURN:
        begin
          nxt_carry = SAVED_STATUS_WORD[STATUS_CARRY_POS];
          nxt_overflow = SAVED_STATUS_WORD[STATUS_OVERFLOW_POS];
          nxt_sign = SAVED_STATUS_WORD[STATUS_SIGN_POS];
          nxt_zero = SAVED_STATUS_WORD[STATUS_ZERO_POS];
        end
        default:
        begin
          nxt_result = WORD_RST;
        end
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      result_ff <= WORD_RST;
      result_we_ff <= 1'b0;
      dest_ff <= DEST_NONE;
    end
    else
    begin
      result_ff <= nxt_result;
      result_we_ff <= nxt_result_we;
      dest_ff <= nxt_dest;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      high_ff <= WORD_RST;
      high_we_ff <= 1'b0;
    end
    else
    begin
      high_we_ff <= ISSUE && (OPCODE == OP_UNSIGNED_MUL);
      if (ISSUE && (OPCODE == OP_UNSIGNED_MUL))
      begin
        high_ff <= prod_u[63:32];
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      port_addr_ff <= WORD_RST;
      port_data_ff <= WORD_RST;
      port_lanes_ff <= LANES_NONE;
      port_we_ff <= 1'b0;
    end
    else
    begin
      port_we_ff <= 1'b0;
      port_lanes_ff <= LANES_NONE;
      if (ISSUE && (OPCODE == OP_PORT_BYTE))
      begin
        port_we_ff <= 1'b1;
        port_addr_ff <= port_base;
        port_data_ff <= SRC_REG2 & BYTE_DATA_MASK;
        port_lanes_ff <= LANES_BYTE;
      end
      else if (ISSUE && (OPCODE == OP_PORT_HALF))
      begin
        port_we_ff <= 1'b1;
        port_addr_ff <= port_base & HALF_ADDR_MASK;
        port_data_ff <= SRC_REG2 & HALF_DATA_MASK;
        port_lanes_ff <= LANES_HALF;
      end
      else if (ISSUE && (OPCODE == OP_PORT_WORD))
      begin
        port_we_ff <= 1'b1;
        port_addr_ff <= port_base & WORD_ADDR_MASK;
        port_data_ff <= SRC_REG2;
        port_lanes_ff <= LANES_WORD;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      pc_ff <= WORD_RST;
      pc_load_ff <= 1'b0;
    end
    else
    begin
      pc_load_ff <= ISSUE && (OPCODE == OP_TRAP_RETURN);
      if (ISSUE && (OPCODE == OP_TRAP_RETURN))
      begin
        pc_ff <= SAVED_PC;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      carry_ff <= FLAG_RST;
      overflow_ff <= FLAG_RST;
      sign_ff <= FLAG_RST;
      zero_ff <= FLAG_RST;
    end
    else
    begin
      carry_ff <= nxt_carry;
      overflow_ff <= nxt_overflow;
      sign_ff <= nxt_sign;
      zero_ff <= nxt_zero;
    end
  end

  // A clamp in the same cycle as a clear must not be lost
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      clip_flag_ff <= FLAG_RST;
    end
    else
    begin
      clip_flag_ff <= clip_event || (clip_flag_ff && !SATURATION_CLEAR);
    end
  end

  assign RESULT_DATA = result_ff;
  assign RESULT_WRITE = result_we_ff;
  assign RESULT_DEST = dest_ff;
  assign PRODUCT_HIGH_REGISTER = high_ff;
  assign PRODUCT_HIGH_WRITE = high_we_ff;
  assign PORT_ADDRESS = port_addr_ff;
  assign PORT_DATA = port_data_ff;
  assign PORT_LANES = port_lanes_ff;
  assign PORT_WRITE = port_we_ff;
  assign PC_VALUE = pc_ff;
  assign PC_LOAD = pc_load_ff;
  assign CARRY_FLAG = carry_ff;
  assign OVERFLOW_FLAG = overflow_ff;
  assign SIGN_FLAG = sign_ff;
  assign ZERO_FLAG = zero_ff;
  assign SATURATION_FLAG = clip_flag_ff;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  mul_imm_fit_a: assert property (ISSUE && OPCODE == OP_CLAMP_MUL_IMM && !ovf_mul
    |=> RESULT_WRITE && RESULT_DEST == DEST_REG2 && RESULT_DATA == $past(prod_imm[31:0]))
    else $error("immediate multiply result wrong");
  clamp_limit_a: assert property (ISSUE && clip_event
    |=> SATURATION_FLAG && (RESULT_DATA == CLIP_POS_MAX || RESULT_DATA == CLIP_NEG_MAX))
    else $error("clamp limit not applied");
  mul_high_a: assert property (ISSUE && OPCODE == OP_CLAMP_MUL_HIGH
    |=> RESULT_DEST == DEST_REG3 && RESULT_DATA == $past(prod_reg[63:32]))
    else $error("high product wrong");
  umul_carry_a: assert property (ISSUE && OPCODE == OP_UNSIGNED_MUL
    |=> PRODUCT_HIGH_WRITE && $stable(CARRY_FLAG) && RESULT_DATA == $past(prod_u[31:0]))
    else $error("unsigned multiply wrong");
  not_flags_a: assert property (ISSUE && OPCODE == OP_NOT
    |=> !OVERFLOW_FLAG && RESULT_DATA == ~$past(SRC_REG1) && ZERO_FLAG == (RESULT_DATA == WORD_RST))
    else $error("complement wrong");
  port_half_a: assert property (PORT_WRITE && PORT_LANES == LANES_HALF
    |-> PORT_ADDRESS[0] == 1'b0 && PORT_DATA[31:16] == 16'h0000)
    else $error("halfword port misaligned");
  port_word_a: assert property (ISSUE && OPCODE == OP_PORT_WORD
    |=> PORT_WRITE && PORT_ADDRESS[1:0] == 2'h0 && PORT_DATA == $past(SRC_REG2))
    else $error("word port wrong");
  trap_reload_a: assert property (ISSUE && OPCODE == OP_TRAP_RETURN
    |=> PC_LOAD && PC_VALUE == $past(SAVED_PC)
        && CARRY_FLAG == $past(SAVED_STATUS_WORD[STATUS_CARRY_POS]))
    else $error("trap return reload wrong");
  shift_left_a: assert property (ISSUE && OPCODE == OP_LSL_REG
    |=> RESULT_DATA == ($past(SRC_REG2) << $past(SRC_REG1[4:0])) && !OVERFLOW_FLAG)
    else $error("left shift wrong");
  flag_stick_a: assert property (SATURATION_FLAG && !SATURATION_CLEAR
    |=> SATURATION_FLAG)
    else $error("saturation flag dropped");

endmodule : cxms_exec

// [verification/cxms_decode_model.sv]
module cxms_decode_model (
  input wire logic clk,
  output logic issue,
  output cxms_pkg::cxms_op_type opcode,
  output logic [31:0] src1,
  output logic [31:0] src2,
  output logic [31:0] src3,
  output logic [15:0] immediate_16bit,
  output logic [4:0] immediate_5bit,
  output logic [15:0] disp,
  output logic [31:0] saved_pc,
  output logic [31:0] saved_sw,
  output logic sat_clear
);
  timeunit 1ns;
  timeprecision 1ns;
  import cxms_pkg::*;

  initial
  begin
    issue = 1'h0;
    opcode = OP_IDLE;
    src1 = '0;
    src2 = '0;
    src3 = '0;
    immediate_16bit = '0;
    immediate_5bit = '0;
    disp = '0;
    saved_pc = '0;
    saved_sw = '0;
    sat_clear = 1'h0;
  end

  // Saved system registers share operand lanes to keep calls short
  task automatic send(input cxms_op_type op, input logic [31:0] r1, input logic [31:0] r2,
      input logic [31:0] r3, input logic [15:0] imm, input logic clr);
    @(posedge clk);
    issue <= 1'h1;
    opcode <= op;
    src1 <= r1;
    src2 <= r2;
    src3 <= r3;
    immediate_16bit <= imm;
    immediate_5bit <= imm[4:0];
    disp <= imm;
    saved_sw <= r1;
    saved_pc <= r3;
    sat_clear <= clr;
  endtask : send

  task automatic idle();
    @(posedge clk);
    issue <= 1'h0;
    opcode <= OP_IDLE;
    sat_clear <= 1'h0;
  endtask : idle
endmodule : cxms_decode_model

// [verification/cxms_exec_tb.sv]
module cxms_exec_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cxms_pkg::*;

  typedef struct {
    logic [31:0] data;
    logic [1:0] dest;
    logic rw;
    logic hw;
    logic [31:0] hi;
    logic pw;
    logic [31:0] pa;
    logic [31:0] pd;
    logic [3:0] pl;
    logic pcl;
    logic [31:0] pc;
    logic [4:0] fl;
  } cxms_exp_type;

  logic clk, rst_b, issue, sat_clear, res_write, hi_write, port_write, pc_load;
  logic carry, ovf, sign, zero, saturation_flag;
  cxms_op_type opcode;
  logic [31:0] src1, src2, src3, saved_pc, saved_sw, res_data, hi_data;
  logic [31:0] port_addr, port_data, pc_value;
  logic [15:0] immediate_16bit, disp;
  logic [4:0] immediate_5bit;
  logic [1:0] res_dest;
  logic [3:0] port_lanes;
  logic fc = 1'h0, fv = 1'h0, fs = 1'h0, fz = 1'h0, fsat = 1'h0;
  cxms_exp_type exp_q[$];
  cxms_exp_type mon_e;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  cxms_decode_model u_cxms_decode_model (.clk(clk), .issue(issue), .opcode(opcode),
    .src1(src1), .src2(src2), .src3(src3), .immediate_16bit(immediate_16bit), .immediate_5bit(immediate_5bit), .disp(disp),
    .saved_pc(saved_pc), .saved_sw(saved_sw), .sat_clear(sat_clear));

  cxms_exec u_cxms_exec (.CLK(clk), .RST_B(rst_b), .ISSUE(issue), .OPCODE(opcode),
    .SRC_REG1(src1), .SRC_REG2(src2), .SRC_REG3(src3), .IMMEDIATE_16BIT(immediate_16bit),
    .IMMEDIATE_5BIT(immediate_5bit), .DISPLACEMENT_16BIT(disp), .SAVED_PC(saved_pc),
    .SAVED_STATUS_WORD(saved_sw), .SATURATION_CLEAR(sat_clear), .RESULT_DATA(res_data),
    .RESULT_WRITE(res_write), .RESULT_DEST(res_dest), .PRODUCT_HIGH_REGISTER(hi_data),
    .PRODUCT_HIGH_WRITE(hi_write), .PORT_ADDRESS(port_addr), .PORT_DATA(port_data),
    .PORT_LANES(port_lanes), .PORT_WRITE(port_write), .PC_VALUE(pc_value),
    .PC_LOAD(pc_load), .CARRY_FLAG(carry), .OVERFLOW_FLAG(ovf), .SIGN_FLAG(sign),
    .ZERO_FLAG(zero), .SATURATION_FLAG(saturation_flag));

  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // Expected results follow the issue order; flags are tracked here in step
  task automatic go(input cxms_op_type op, input logic [31:0] r1, input logic [31:0] r2,
      input logic [31:0] r3, input logic [15:0] imm, input logic clr);
    cxms_exp_type e;
    logic signed [63:0] p;
    logic [63:0] w;
    logic [4:0] sh;
    logic ovs;
    logic t;
    e = '{default: '0};
    w = '0;
    t = 1'h0;
    sh = (op inside {OP_ASR_REG, OP_LSL_REG, OP_CONCAT_LSL}) ? r1[4:0] : imm[4:0];
    case (op)
      OP_CLAMP_MUL_IMM: p = $signed(r1) * $signed({{16{imm[15]}}, imm});
      OP_CLAMP_ADD: p = $signed(r2) + $signed(r1);
      OP_CLAMP_SUB: p = $signed(r2) - $signed(r1);
      OP_CLAMP_MUL_HIGH: p = $signed(r1) * $signed(r2);
      default: p = '0;
    endcase
    ovs = (p[63:31] != {33{p[63]}}) && (op inside {OP_CLAMP_MUL_IMM, OP_CLAMP_ADD, OP_CLAMP_SUB});
    e.data = ovs ? (p[63] ? CLIP_NEG_MAX : CLIP_POS_MAX) : p[31:0];
    e.dest = DEST_REG2;
    e.rw = 1'h1;
    e.pa = r1 + {{16{imm[15]}}, imm};
    case (op)
      OP_CLAMP_MUL_HIGH, OP_CLAMP_ADD, OP_CLAMP_SUB:
      begin
        e.dest = DEST_REG3;
        if (op == OP_CLAMP_MUL_HIGH)
          e.data = p[63:32];
        w = {32'h0000_0000, r1} + {32'h0000_0000, r2};
        if (op != OP_CLAMP_MUL_HIGH)
          fc = (op == OP_CLAMP_ADD) ? w[32] : (r2 < r1);
      end
      OP_UNSIGNED_MUL:
      begin
        w = {32'h0000_0000, r1} * {32'h0000_0000, r2};
        e.data = w[31:0];
        e.hw = 1'h1;
        e.hi = w[63:32];
      end
      OP_NOT: e.data = ~r1;
      OP_OR: e.data = r1 | r2;
      OP_OR_IMM: e.data = r1 | {16'h0000, imm};
      OP_PORT_BYTE, OP_PORT_HALF, OP_PORT_WORD:
      begin
        e.rw = 1'h0;
        e.pw = 1'h1;
        e.pd = r2 & BYTE_DATA_MASK;
        e.pl = LANES_BYTE;
        if (op == OP_PORT_HALF)
          {e.pa, e.pd, e.pl} = {e.pa & HALF_ADDR_MASK, r2 & HALF_DATA_MASK, LANES_HALF};
        if (op == OP_PORT_WORD)
          {e.pa, e.pd, e.pl} = {e.pa & WORD_ADDR_MASK, r2, LANES_WORD};
      end
      OP_TRAP_RETURN:
      begin
        e.rw = 1'h0;
        e.pcl = 1'h1;
        e.pc = r3;
        {fc, fv, fs, fz} = {r1[STATUS_CARRY_POS], r1[STATUS_OVERFLOW_POS],
          r1[STATUS_SIGN_POS], r1[STATUS_ZERO_POS]};
      end
      OP_ASR_REG, OP_ASR_IMM:
      begin
        e.data = $signed(r2) >>> sh;
        fc = (sh != 5'h00) && r2[sh - 5'h01];
      end
      OP_LSL_REG, OP_LSL_IMM:
      begin
        e.data = r2 << sh;
        fc = (sh != 5'h00) && r2[6'h20 - {1'h0, sh}];
      end
      OP_FLAG_TO_REG:
      begin
        case (imm[2:0])
          3'h0: t = fv;
          3'h1: t = fc;
          3'h2: t = fz;
          3'h3: t = fc | fz;
          3'h4: t = fs;
          3'h5: t = 1'h1;
          3'h6: t = fs ^ fv;
          default: t = (fs ^ fv) | fz;
        endcase
        e.data = {31'h0000_0000, t ^ imm[3]};
      end
      OP_CONCAT_LSL:
      begin
        w = {r3, r2} << sh;
        e.data = w[63:32];
        e.dest = DEST_REG3;
      end
      OP_CLAMP_MUL_IMM: e.rw = 1'h1;
      default: e.rw = 1'h0;
    endcase
    if (op inside {OP_NOT, OP_OR, OP_OR_IMM, OP_ASR_REG, OP_ASR_IMM, OP_LSL_REG, OP_LSL_IMM,
        OP_CLAMP_ADD, OP_CLAMP_SUB})
      {fv, fs, fz} = {ovs, e.data[31], e.data == 32'h0000_0000};
    if (op == OP_UNSIGNED_MUL)
      {fv, fs, fz} = {|w[63:32], w[63], w == 64'h0000_0000_0000_0000};
    fsat = ovs | (fsat & ~clr);
    e.fl = {fc, fv, fs, fz, fsat};
    if (op != OP_IDLE)
      exp_q.push_back(e);
    u_cxms_decode_model.send(op, r1, r2, r3, imm, clr);
  endtask : go

  always @(negedge clk)
  begin
    if (res_write === 1'h1 || hi_write === 1'h1 || port_write === 1'h1 || pc_load === 1'h1)
    begin
      if (exp_q.size() == 0)
        check(64'h0000_0000_0000_0001, 64'h0000_0000_0000_0000);
      else
      begin
        mon_e = exp_q.pop_front();
        check({res_write, hi_write, port_write, pc_load},
          {mon_e.rw, mon_e.hw, mon_e.pw, mon_e.pcl});
        check({carry, ovf, sign, zero, saturation_flag}, mon_e.fl);
        if (mon_e.rw)
          check({res_dest, res_data}, {mon_e.dest, mon_e.data});
        if (mon_e.hw)
          check(hi_data, mon_e.hi);
        if (mon_e.pw)
          check({port_lanes, port_addr}, {mon_e.pl, mon_e.pa});
        if (mon_e.pw)
          check(port_data, mon_e.pd);
        if (mon_e.pcl)
          check(pc_value, mon_e.pc);
      end
    end
  end

  // Whole run is about 150 cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      num_errors = num_errors + 1;
      report_and_stop();
    end
  end

  initial
  begin
    void'($urandom(32'h0000_5303));
    rst_b = 1'h0;
    repeat (12) @(posedge clk);
    rst_b <= 1'h1;
    @(negedge clk);
    check({res_write, hi_write, port_write, pc_load, carry, ovf, sign, zero, saturation_flag}, '0);
    go(OP_CLAMP_ADD, 32'h7FFF_FFFF, 32'h0000_0001, '0, '0, 1'h0);
    go(OP_CLAMP_SUB, 32'h0000_0001, 32'h8000_0000, '0, '0, 1'h0);
    go(OP_NOT, 32'h1234_5678, '0, '0, '0, 1'h1);
    go(OP_CLAMP_ADD, 32'h0000_0005, 32'hFFFF_FFFB, '0, '0, 1'h0);
    go(OP_CLAMP_MUL_IMM, 32'h7FFF_FFFF, '0, '0, 16'h0002, 1'h0);
    go(OP_CLAMP_MUL_IMM, 32'h7FFF_FFFF, '0, '0, 16'hFFFE, 1'h1);
    go(OP_CLAMP_MUL_IMM, 32'hFFFF_FFFD, '0, '0, 16'hFFFF, 1'h1);
    go(OP_CLAMP_MUL_HIGH, 32'h8000_0000, 32'h8000_0000, '0, '0, 1'h0);
    go(OP_UNSIGNED_MUL, 32'hFFFF_FFFF, 32'hFFFF_FFFF, '0, '0, 1'h0);
    go(OP_UNSIGNED_MUL, '0, 32'h0000_0005, '0, '0, 1'h0);
    go(OP_OR, 32'hF0F0_0000, 32'h0000_0F0F, '0, '0, 1'h0);
    go(OP_OR_IMM, 32'h0001_0000, '0, '0, 16'h8001, 1'h0);
    go(OP_LSL_REG, 32'h0000_0020, 32'h8000_0001, '0, '0, 1'h0);
    go(OP_LSL_IMM, '0, 32'h0000_0003, '0, 16'h001F, 1'h0);
    go(OP_ASR_REG, 32'h0000_003F, 32'h8000_0000, '0, '0, 1'h0);
    go(OP_ASR_IMM, '0, 32'h0000_0003, '0, 16'h0001, 1'h0);
    go(OP_CONCAT_LSL, 32'h0000_0004, 32'hF000_0000, 32'h0123_4567, '0, 1'h0);
    go(OP_PORT_HALF, 32'h0000_1001, 32'hAABB_CCDD, '0, 16'h0002, 1'h0);
    go(OP_PORT_BYTE, 32'h0000_1000, 32'hAABB_CCDD, '0, 16'hFFFF, 1'h0);
    go(OP_PORT_WORD, 32'h0000_1007, 32'hAABB_CCDD, '0, '0, 1'h0);
    go(OP_TRAP_RETURN, 32'h0000_000A, '0, 32'h0000_4000, '0, 1'h0);
    for (int i = 0; i < 16; i++)
    begin
      go(OP_CLAMP_SUB, $urandom_range(3), i[1] ? 32'h8000_0000 : $urandom_range(3),
        '0, '0, 1'h1);
      go(OP_FLAG_TO_REG, $urandom, $urandom, '0, i[15:0], 1'h0);
    end
    repeat (80)
      go(cxms_op_type'(5'($urandom_range(18, 1))), $urandom, $urandom, $urandom,
        16'($urandom), $urandom_range(7) == 0);
    u_cxms_decode_model.idle();
    repeat (3) @(posedge clk);
    check(64'(exp_q.size()), '0);
    report_and_stop();
  end
endmodule : cxms_exec_tb
